// *** tpm_regs.svh ***
`ifndef TPM_REGS_SVH
`define TPM_REGS_SVH

// event codes
`define TPM_EV_CYCLE      16'h0000
`define TPM_EV_CYCLE64    16'h0001
`define TPM_EV_ALLOC      16'h0008
`define TPM_EV_ALLOC_RD   16'h0009
`define TPM_EV_ALLOC_WR   16'h000A
`define TPM_EV_ACCESS     16'h0010
`define TPM_EV_ACCESS_RD  16'h0011
`define TPM_EV_ACCESS_WR  16'h0012
`define TPM_EV_ARCH_LAST  16'h007F
// cycle divider
`define TPM_DIV64         6'h3F
// architectural limits
`define TPM_MAX_COUNTERS  256
`define TPM_MAX_GROUPS    256
`define TPM_MAX_PER_GROUP 15
// filter type encodings
`define TPM_FILT_GLOBAL   2'h0
`define TPM_FILT_CONTEXT  2'h1
`define TPM_FILT_STREAM   2'h2
// bank monitor control bit positions
`define TPM_BMC_ENABLE    0
`define TPM_BMC_RESET     1

`endif

// *** tpm_pkg.sv ***
package tpm_pkg;
   typedef logic [15:0] tpm_event_t;
   typedef logic [1:0]  tpm_filt_t;
endpackage : tpm_pkg

// *** tpm_monitor.sv ***
`timescale 1ns/100ps
`include "tpm_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// [RL1] code 0 counts every cycle; code 1 counts every 64th cycle
// [RL2] allocation events counted, split into read and write variants
// [RL3] access events counted per new transaction, read and write variants
// [RL4] codes up to 0x7F reserved; higher codes implementation events
// [RL5] counters count only transactions of their affiliated stream group
// [RL6] stream group affiliation fixed per counter group by parameter
// [RL7] at most 256 counters, 256 groups, 15 counters per group
// [RL8] counters numbered by group, group 0 first
// [RL9] global filter counts all transactions in affiliated stream group
// [RL10] context filter counts only transactions of the indexed context
// [RL11] stream filter matches tag under mask; same widths all groups
// [RL12] per-group filter type selects global, context or stream
// [RL13] bank assign enable exposes group in indexed context bank
// [RL14] software must not assign two groups to one bank
// [RL15] software enables bank assign only with context or stream filter
// [RL16] group control and stream match never visible in a bank
// [RL17] bank view numbers counters from 0 and reports group count only
// [RL18] global monitor control acts only on unassigned groups
// [RL19] bank monitor control drives assigned group, mirrored in group
// [RL20] bank with no assigned group reads zero, ignores writes
// [RL21] overflow irq enabled per counter by set and clear views
// [RL22] each group drives its own overflow interrupt output
// [RL23] secure events counted only with secure enable or debug input
// [RL24] overflow wraps to zero and sets sticky flag driving the irq
module tpm_monitor #(
   parameter int NG    = 2,               // counter groups
   parameter int CPG   = 4,               // counters per group
   parameter int CW    = 32,              // counter width
   parameter int SW    = 8,               // stream tag width
   parameter int XW    = 4,               // context index width
   parameter int NSG   = 2,               // stream tag groups
   parameter logic [NG*8-1:0]  GRP_SG  = '0,  // affiliation per group
   parameter logic [NSG*(1<<SW)-1:0] SG_MEMBER = '1 // membership map
) (
   input  wire logic                       sys_clk,
   input  wire logic                       resetn,
   // transaction events
   input  wire logic                       ev_alloc,
   input  wire logic                       ev_access,
   input  wire logic                       ev_write,
   input  wire logic                       ev_secure,
   input  wire logic [SW-1:0]              source_stream_tag,
   input  wire logic [XW-1:0]              ev_context,
   input  wire logic                       secure_monitor_enable,
   input  wire logic                       secure_debug_count_enable,
   // global monitor control
   input  wire logic                       global_monitor_control_en,
   input  wire logic                       global_monitor_control_rst,
   // per group control, flattened by group
   input  wire logic [NG*XW-1:0]           group_context_index,
   input  wire logic [NG*2-1:0]            group_filter_type,
   input  wire logic [NG-1:0]              bank_assign_enable,
   input  wire logic [NG*SW-1:0]           stream_match_value,
   input  wire logic [NG*SW-1:0]           stream_match_mask,
   // per counter event select, flattened by counter
   input  wire logic [NG*CPG*16-1:0]       counter_event_sel,
   input  wire logic [NG*CPG-1:0]          overflow_irq_set_enable,
   input  wire logic [NG*CPG-1:0]          overflow_irq_clear_enable,
   input  wire logic [NG*CPG-1:0]          overflow_clear,
   // bank side access
   input  wire logic [XW-1:0]              bank_sel,
   input  wire logic                       bank_monitor_control_wr,
   input  wire logic [1:0]                 bank_monitor_control_wdata,
   input  wire logic [3:0]                 bank_cnt_idx,
   output logic [CW-1:0]                   bank_cnt_rdata,
   output logic [1:0]                      bank_monitor_control_rdata,
   output logic [3:0]                      bank_group_counter_count,
   // status
   output logic [NG*CW*CPG-1:0]            counter_value,
   output logic [NG*CPG-1:0]               overflow_status,
   output logic [NG*CPG-1:0]               irq_enable_status,
   output logic [NG*2-1:0]                 group_bank_control,
   output logic [15:0]                     total_counter_count,
   output logic [8:0]                      counter_group_count,
   output logic [3:0]                      group_counter_count,
   output logic [NG-1:0]                   group_overflow_irq
);

   // flat counter index k = group * CPG + counter within group
   localparam int NC = NG * CPG;

   initial begin
      if (NC > `TPM_MAX_COUNTERS || NG > `TPM_MAX_GROUPS ||
          CPG > `TPM_MAX_PER_GROUP)
         $error("counter configuration out of range"); // RL7
   end

   //////////////////////////////////////////////////////////////////////////
   // reset synchroniser: asserts at once, releases on a clock edge so
   // that no flop sees reset removed inside its setup window
   logic rst_meta_q;
   logic rst_n_q;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // divide-by-64 cycle enable; free running from reset, so the first
   // tick comes on the 64th cycle and counter enables do not shift it
   logic [5:0] div_q;
   wire        tick64 = (div_q == `TPM_DIV64); // RL1
   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         div_q <= 6'h00;
      else
         div_q <= div_q + 6'h01;
   end

   // secure transactions masked unless enabled; the cycle codes are not
   // transactions and bypass this gate
   wire sec_ok = !ev_secure || secure_monitor_enable ||
                 secure_debug_count_enable; // RL23

   // configuration reporting
   // constants, so software sees the sizes that were built
   assign total_counter_count = 16'(NC);
   assign counter_group_count = 9'(NG);
   assign group_counter_count = 4'(CPG);

   // bank lookup: first group assigned to the selected bank; two groups
   // on one bank is a software error, and the lowest group then wins
   logic [NG-1:0] bank_hit;
   logic          bank_any;
   logic [7:0]    bank_grp;
   always_comb
   begin
      bank_any = 1'b0;
      bank_grp = 8'h00;
      for (int g = NG - 1; g >= 0; g--)
      begin
         if (bank_hit[g])
         begin
            bank_any = 1'b1;
            bank_grp = 8'(g);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // per group logic
   logic [NG*2-1:0] bmc_q;
   genvar gi, ci;
   generate
      for (gi = 0; gi < NG; gi++)
      begin : g_grp
         wire [XW-1:0] ndx   = group_context_index[gi*XW +: XW];
         tpm_pkg::tpm_filt_t ftyp;
         assign ftyp = group_filter_type[gi*2 +: 2];
         wire [SW-1:0] smv   = stream_match_value[gi*SW +: SW];
         wire [SW-1:0] smm   = stream_match_mask[gi*SW +: SW];
         wire [7:0]    sg    = GRP_SG[gi*8 +: 8];
         wire in_sg = SG_MEMBER[32'(sg) * (1 << SW) +
                                32'(source_stream_tag)]; // RL5 RL6
         wire ctx_hit = (ev_context == ndx); // RL10
         wire sid_hit = ((source_stream_tag ^ smv) & ~smm) == '0; // RL11
         // filter type select; the spare encoding matches nothing
         wire filt_ok = (ftyp == `TPM_FILT_GLOBAL)  ? 1'b1 :   // RL9
                        (ftyp == `TPM_FILT_CONTEXT) ? ctx_hit :
                        (ftyp == `TPM_FILT_STREAM)  ? sid_hit :
                        1'b0; // RL12
         wire txn_ok = in_sg && filt_ok && sec_ok;
         // qualified transaction events shared by the group's counters
         wire alloc_any = ev_alloc && txn_ok; // RL2
         wire alloc_rd  = alloc_any && !ev_write;
         wire alloc_wr  = alloc_any && ev_write;
         wire acc_any   = ev_access && txn_ok; // RL3
         wire acc_rd    = acc_any && !ev_write;
         wire acc_wr    = acc_any && ev_write;
         wire assigned = bank_assign_enable[gi]; // RL13
         assign bank_hit[gi] = assigned && (ndx == bank_sel);
         // control source: bank control when assigned, else global
         wire bwr = bank_monitor_control_wr && bank_any &&
                    (bank_grp == 8'(gi)); // RL20
         wire g_en  = assigned ? bmc_q[gi*2 + `TPM_BMC_ENABLE]
                               : global_monitor_control_en; // RL18 RL19
         wire g_rst = assigned ? (bwr &&
                      bank_monitor_control_wdata[`TPM_BMC_RESET])
                               : global_monitor_control_rst; // RL18
         // bank control register, mirrored for save and restore; the reset
         // bit is a strobe and is never stored
         always_ff @(posedge sys_clk or negedge rst_n_q)
         begin
            if (!rst_n_q)
               bmc_q[gi*2 +: 2] <= 2'h0;
            else if (bwr)
               bmc_q[gi*2 +: 2] <= {1'b0,
                  bank_monitor_control_wdata[`TPM_BMC_ENABLE]}; // RL19
         end
         assign group_bank_control[gi*2 +: 2] = bmc_q[gi*2 +: 2]; // RL19

         for (ci = 0; ci < CPG; ci++)
         begin : g_cnt
            localparam int K = gi * CPG + ci; // RL8
            tpm_pkg::tpm_event_t sel;
            assign sel = counter_event_sel[K*16 +: 16];
            // event decode; reserved codes never count
            wire hit =
               (sel == `TPM_EV_CYCLE)     ? 1'b1      :
               (sel == `TPM_EV_CYCLE64)   ? tick64    :
               (sel == `TPM_EV_ALLOC)     ? alloc_any :
               (sel == `TPM_EV_ALLOC_RD)  ? alloc_rd  :
               (sel == `TPM_EV_ALLOC_WR)  ? alloc_wr  :
               (sel == `TPM_EV_ACCESS)    ? acc_any   :
               (sel == `TPM_EV_ACCESS_RD) ? acc_rd    :
               (sel == `TPM_EV_ACCESS_WR) ? acc_wr    :
               1'b0; // RL1 RL2 RL3 RL4
            logic [CW-1:0] cnt_q;
            logic          ovf_q;
            logic          ien_q;
            wire inc  = g_en && hit;
            wire wrap = inc && (cnt_q == '1);
            // counter wraps to zero on overflow
            // a reset strobe wins over a same-cycle increment
            always_ff @(posedge sys_clk or negedge rst_n_q)
            begin
               if (!rst_n_q)
                  cnt_q <= '0;
               else if (g_rst)
                  cnt_q <= '0;
               else if (inc)
                  cnt_q <= cnt_q + CW'(1); // RL24
            end
            // sticky overflow, set wins over clear so that a wrap landing
            // on the clear strobe is never lost
            always_ff @(posedge sys_clk or negedge rst_n_q)
            begin
               if (!rst_n_q)
                  ovf_q <= 1'b0;
               else if (wrap)
                  ovf_q <= 1'b1; // RL24
               else if (overflow_clear[K])
                  ovf_q <= 1'b0;
            end
            // irq enable, set view wins over clear view
            always_ff @(posedge sys_clk or negedge rst_n_q)
            begin
               if (!rst_n_q)
                  ien_q <= 1'b0;
               else if (overflow_irq_set_enable[K])
                  ien_q <= 1'b1; // RL21
               else if (overflow_irq_clear_enable[K])
                  ien_q <= 1'b0; // RL21
            end
            assign counter_value[K*CW +: CW] = cnt_q;
            assign overflow_status[K]        = ovf_q;
            assign irq_enable_status[K]      = ien_q;
         end

         // group interrupt, registered so the pin never glitches while
         // flags and enables change in the same cycle
         always_ff @(posedge sys_clk or negedge rst_n_q)
         begin
            if (!rst_n_q)
               group_overflow_irq[gi] <= 1'b0;
            else
               group_overflow_irq[gi] <= |(overflow_status[gi*CPG +: CPG] &
                  irq_enable_status[gi*CPG +: CPG]); // RL22 RL24
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // bank view: group-local counter numbering, zero when unassigned;
   // an index past the group's last counter reads zero as well
   wire [15:0] bank_k = 16'(bank_grp) * 16'(CPG) + 16'(bank_cnt_idx);
   wire        bank_idx_ok = bank_any && (32'(bank_cnt_idx) < CPG);
   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         bank_cnt_rdata             <= '0;
         bank_monitor_control_rdata <= 2'h0;
         bank_group_counter_count   <= 4'h0;
      end
      else
      begin
         bank_cnt_rdata <= bank_idx_ok ?
            counter_value[32'(bank_k)*CW +: CW] : '0; // RL17 RL20
         bank_monitor_control_rdata <= bank_any ?
            bmc_q[32'(bank_grp)*2 +: 2] : 2'h0; // RL16 RL20
         bank_group_counter_count <= bank_any ? 4'(CPG) : 4'h0; // RL17
      end
   end

endmodule : tpm_monitor

// *** tpm_monitor_chk.sv ***
`timescale 1ns/100ps
`include "tpm_regs.svh"
module tpm_monitor_chk #(
   parameter int NG  = 2,
   parameter int CPG = 4,
   parameter int CW  = 32,
   parameter int XW  = 4
) (
   input wire logic                sys_clk,
   input wire logic                resetn,
   input wire logic                global_monitor_control_en,
   input wire logic                global_monitor_control_rst,
   input wire logic [NG*XW-1:0]    group_context_index,
   input wire logic [NG-1:0]       bank_assign_enable,
   input wire logic [NG*CPG*16-1:0] counter_event_sel,
   input wire logic [NG*CPG-1:0]   overflow_irq_set_enable,
   input wire logic [NG*CPG-1:0]   overflow_irq_clear_enable,
   input wire logic [NG*CPG-1:0]   overflow_clear,
   input wire logic [XW-1:0]       bank_sel,
   input wire logic                bank_monitor_control_wr,
   input wire logic [1:0]          bank_monitor_control_wdata,
   input wire logic [CW-1:0]       bank_cnt_rdata,
   input wire logic [1:0]          bank_monitor_control_rdata,
   input wire logic [3:0]          bank_group_counter_count,
   input wire logic [NG*CW*CPG-1:0] counter_value,
   input wire logic [NG*CPG-1:0]   overflow_status,
   input wire logic [NG*CPG-1:0]   irq_enable_status,
   input wire logic [15:0]         total_counter_count,
   input wire logic [8:0]          counter_group_count,
   input wire logic [3:0]          group_counter_count,
   input wire logic [NG-1:0]       group_overflow_irq
);
   logic [1:0] rel_q;
   // edges since release, covers the internal reset synchroniser
   wire rdy = (rel_q == 2'h3);
   wire [CW-1:0] c0 = counter_value[CW-1:0];
   wire go0 = rdy && global_monitor_control_en
      && !global_monitor_control_rst && !bank_assign_enable[0];
   wire bsel0 = rdy && bank_assign_enable[0]
      && (bank_sel == group_context_index[XW-1:0]);
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rel_q <= 2'h0;
      else if (!rdy)
         rel_q <= rel_q + 2'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence cyc0_s;
      go0 && (counter_event_sel[15:0] == `TPM_EV_CYCLE);
   endsequence
   sequence wrap0_s;
      go0 && (counter_event_sel[15:0] == `TPM_EV_CYCLE) && (c0 == '1);
   endsequence
   cycle_step_a: assert property (cyc0_s |=> c0 == $past(c0) + 1'b1)
      else $error("cycle counter did not step");
   wrap_flag_a: assert property (wrap0_s |=> c0 == 0 && overflow_status[0])
      else $error("wrap did not clear counter and set flag");
   flag_clear_a: assert property (rdy && overflow_clear[0] && c0 != '1
      |=> !overflow_status[0]) else $error("overflow flag not cleared");
   group_irq_a: assert property (rdy |=> group_overflow_irq[0] ==
      $past(|(overflow_status[CPG-1:0] & irq_enable_status[CPG-1:0])))
      else $error("group interrupt wrong");
   en_set_a: assert property (rdy && overflow_irq_set_enable[0]
      |=> irq_enable_status[0]) else $error("irq enable not set");
   en_clear_a: assert property (rdy && overflow_irq_clear_enable[0]
      && !overflow_irq_set_enable[0] |=> !irq_enable_status[0])
      else $error("irq enable not cleared");
   const_count_a: assert property (total_counter_count == NG*CPG
      && counter_group_count == NG && group_counter_count == CPG)
      else $error("counter counts wrong");
   global_reset_a: assert property (rdy && global_monitor_control_rst
      && !bank_assign_enable[0] |=> c0 == 0) else $error("reset missed");
   bank_empty_a: assert property (rdy && bank_assign_enable == '0
      |=> bank_cnt_rdata == 0 && bank_monitor_control_rdata == 0
      && bank_group_counter_count == 0) else $error("empty bank not zero");
   bank_count_a: assert property (bsel0 |=> bank_group_counter_count == CPG)
      else $error("bank counter count wrong");
   bank_reset_a: assert property (bsel0 && bank_monitor_control_wr
      && bank_monitor_control_wdata[`TPM_BMC_RESET] |=> c0 == 0)
      else $error("bank reset missed");
endmodule : tpm_monitor_chk
bind tpm_monitor tpm_monitor_chk #(.NG(NG), .CPG(CPG), .CW(CW), .XW(XW))
   tpm_monitor_chk_i (.*);

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   localparam int CW = 8;
   // counts expected after the event sequence, counter 0 in the low byte
   localparam logic [63:0] EV_EXP = 64'h00_01_01_05_02_04_02_06;
   logic sys_clk = 0, resetn = 0, ev_alloc = 0, ev_access = 0, ev_write = 0;
   logic ev_secure = 0, sme = 0, sde = 0, gen = 0, grst = 0, bwr = 0;
   logic [7:0]   tag = 0, gidx = 0;
   logic [3:0]   ctx = 0, bsel = 0, bidx = 0, gft = 0, bgc, gcc, gbc;
   logic [1:0]   bae = 0, bwd = 0, bcr, irq;
   logic [15:0]  smv = 0, smm = 0, tcc;
   logic [127:0] sel = 0;
   logic [7:0]   ise = 0, ice = 0, ocl = 0, ovf, ien;
   logic [CW-1:0] brd;
   logic [63:0]  cv;
   logic [8:0]   cgc;
   int failures = 0, total_checks = 0;
   tpm_monitor #(.CW(CW), .GRP_SG(16'h0100),
      .SG_MEMBER({{128{1'b0}}, {384{1'b1}}})) tpm_monitor_i (
      .sys_clk(sys_clk), .resetn(resetn), .ev_alloc(ev_alloc),
      .ev_access(ev_access), .ev_write(ev_write), .ev_secure(ev_secure),
      .source_stream_tag(tag), .ev_context(ctx),
      .secure_monitor_enable(sme), .secure_debug_count_enable(sde),
      .global_monitor_control_en(gen), .global_monitor_control_rst(grst),
      .group_context_index(gidx), .group_filter_type(gft),
      .bank_assign_enable(bae), .stream_match_value(smv),
      .stream_match_mask(smm), .counter_event_sel(sel),
      .overflow_irq_set_enable(ise), .overflow_irq_clear_enable(ice),
      .overflow_clear(ocl), .bank_sel(bsel), .bank_monitor_control_wr(bwr),
      .bank_monitor_control_wdata(bwd), .bank_cnt_idx(bidx),
      .bank_cnt_rdata(brd), .bank_monitor_control_rdata(bcr),
      .bank_group_counter_count(bgc), .counter_value(cv),
      .overflow_status(ovf), .irq_enable_status(ien),
      .group_bank_control(gbc), .total_counter_count(tcc),
      .counter_group_count(cgc), .group_counter_count(gcc),
      .group_overflow_irq(irq));
   // free running clock
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // one transaction event, then an idle cycle
   task automatic ev(input logic acc, wr, input logic [7:0] t,
      input logic [3:0] c, input logic sec);
      {ev_access, ev_alloc, ev_write, tag, ctx, ev_secure} =
         {acc, !acc, wr, t, c, sec};
      tick(1);
      {ev_access, ev_alloc} = 2'h0;
      tick(1);
   endtask : ev
   task automatic wb(input logic [3:0] b, input logic [1:0] d);
      {bsel, bwd, bwr} = {b, d, 1'b1};
      tick(1);
      bwr = 0;
      tick(1);
   endtask : wb
   task automatic pulse_rst;
      grst = 1;
      tick(1);
      grst = 0;
   endtask : pulse_rst
   function automatic logic [CW-1:0] cnt(input int k);
      return cv[k*CW +: CW];
   endfunction : cnt
   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   // watchdog well beyond the expected run
   initial
   begin
      #50000;
      failures++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(8);
      resetn = 1;
      tick(4);
      chk(tcc, 16'h0008);
      chk(cgc, 9'h002);
      chk(gcc, 4'h4);
      chk(ovf, 8'h00);
      sel = {{6{16'h0020}}, 16'h0001, 16'h0000};
      gen = 1;
      tick(128);
      gen = 0;
      chk(cnt(0), 8'h80);
      chk(cnt(1), 8'h02);
      pulse_rst();
      chk(cnt(0), 8'h00);
      // event codes, affiliation, reserved code and secure gating
      sel = {16'h0020, 16'h000A, 16'h0009, 16'h0010,
             16'h0008, 16'h0012, 16'h0011, 16'h0010};
      gen = 1;
      ev(1, 0, 8'h10, 0, 0);
      ev(1, 1, 8'h10, 0, 0);
      ev(1, 1, 8'h10, 0, 0);
      ev(0, 0, 8'h10, 0, 0);
      ev(0, 1, 8'h10, 0, 0);
      ev(1, 0, 8'h90, 0, 0);
      ev(1, 0, 8'h10, 0, 1);
      sde = 1;
      ev(1, 1, 8'h10, 0, 1);
      {sde, sme} = 2'b01;
      ev(1, 1, 8'h10, 0, 1);
      sme = 0;
      for (int k = 0; k < 8; k++)
         chk(cnt(k), EV_EXP[k*8 +: 8]);
      // context filter on group 0, stream filter on group 1
      {gft, gidx, smv, smm} = {4'h9, 8'h03, 16'h5A00, 16'h0F00};
      pulse_rst();
      ev(1, 0, 8'h50, 3, 0);
      ev(1, 0, 8'h5F, 2, 0);
      ev(1, 0, 8'h40, 3, 0);
      ev(1, 0, 8'h4A, 3, 0);
      chk(cnt(0), 8'h03);
      chk(cnt(4), 8'h02);
      // spare filter type on group 1 counts nothing
      gft = 4'hD;
      ev(1, 0, 8'h50, 3, 0);
      chk(cnt(4), 8'h02);
      chk(cnt(0), 8'h04);
      // group 0 revealed in bank 3, global control off
      {bae, gen} = 3'b010;
      wb(3, 2'h1);
      chk(gbc, 4'h1);
      chk(bcr, 2'h1);
      chk(bgc, 4'h4);
      ev(1, 0, 8'h50, 3, 0);
      chk(cnt(0), 8'h05);
      chk(cnt(4), 8'h02);
      chk(brd, 8'h05);
      wb(5, 2'h0);
      chk({brd, bcr, bgc}, 14'h0);
      bsel = 3;
      tick(2);
      chk(bcr, 2'h1);
      wb(3, 2'h3);
      chk(cnt(0), 8'h00);
      // wrap of counter 0 with its interrupt enabled
      {bae, gft, sel[15:0]} = 0;
      pulse_rst();
      ise = 8'h01;
      tick(1);
      {ise, gen} = 9'h001;
      tick(256);
      gen = 0;
      chk(cnt(0), 8'h00);
      chk(ovf, 8'h01);
      tick(1);
      chk(irq, 2'h1);
      ice = 8'h01;
      tick(1);
      ice = 0;
      tick(1);
      chk(irq, 2'h0);
      ocl = 8'h01;
      tick(1);
      ocl = 0;
      chk(ovf, 8'h00);
      test_done();
   end
endmodule : testbench
